//--- shared/can_flt_regs.svh
`ifndef CAN_FLT_REGS_SVH
`define CAN_FLT_REGS_SVH

// register byte offsets (low address byte only is decoded)
`define OFS_MODCTL 8'h00
`define OFS_RXFLG  8'h04
`define OFS_RXIEN  8'h08
`define OFS_TXFLG  8'h0C
`define OFS_TXCTL  8'h10
`define OFS_FMODE  8'h14
`define OFS_RXERR  8'h18
`define OFS_TXERR  8'h1C
`define OFS_CODE0  8'h20
`define OFS_MASK0  8'h30

// receive flag and enable bit positions (same layout in both)
`define FB_WAKE 7
`define FB_RWRN 6
`define FB_TWRN 5
`define FB_RPAS 4
`define FB_TPAS 3
`define FB_BOFF 2
`define FB_OVR  1
`define FB_FULL 0
`define ERR_BITS 8'h7E

// transmit register fields
`define EMPTY_LSB     0
`define ACK_LSB       4
`define EMPTY_IEN_LSB 0
`define ABT_RQ_LSB    4

// filter mode register fields and codes
`define FMODE_LSB 4
`define FHIT_LSB  0
`define FM_32     2'h0
`define FM_16     2'h1
`define FM_8      2'h2
`define FM_CLOSED 2'h3

// reset values
`define RST_SOFT  1'h1
`define RST_EMPTY 3'h7

// error counter thresholds
`define WARN_LIM 9'h060
`define PASS_LIM 9'h07F
`define BOFF_LIM 9'h0FF

`endif

//--- shared/can_flt_pkg.sv
package can_flt_pkg;

  // bus slave phases
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} bus_state_t;

  // message from the receive engine into the background buffer
  typedef struct packed {
    logic            ext;
    logic [3:0][7:0] id;
  } rx_msg_t;

  // transmit engine status, one bit per buffer
  typedef struct packed {
    logic [2:0] sent;
    logic [2:0] started;
    logic [2:0] failed;
  } tx_stat_t;

endpackage

//--- verilog/can_irq_abort_id_filter.sv
// How it works
// - wake flag with its enable set raises the wake interrupt, else none
// - six error flags each raise error interrupt only when enabled
// - receive-full flag with its enable raises the receive interrupt
// - soft reset holds rx enables, tx flags, tx control in reset state
// - abort acks read-only; tx-empty flags clear on written 1; 0 ignored
// - tx flag register resets on hard or soft reset
// - software clears tx-empty to schedule; device sets it after success
// - abort sets tx-empty and abort ack, then interrupt if enabled
// - clearing tx-empty also clears that buffer's abort ack
// - cpu only sets abort request; cleared when tx-empty becomes set
// - abort granted only before start or after a failed attempt
// - tx-empty with its enable set asserts the transmit interrupt
// - mode field picks 32, 16, 8-bit filters or closed
// - hit field names accepting filter, updated on buffer exchange
// - mode, code and mask registers writable only under soft reset
// - error counters read-only, readable in sleep or soft reset only
// - messages land in background buffer; only accepted ones signalled
// - code and mask per identifier byte; standard uses first two
// - mask 0 demands equal bit, mask 1 ignores; all must match
// - warning, passive and bus-off flags follow the error counters
// - full flag blocks exchange into the foreground buffer
`timescale 1ns/1ps
`default_nettype none
`include "can_flt_regs.svh"

module can_irq_abort_id_filter
  import can_flt_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  input  wire logic        sleep_mode,
  input  wire logic        wake_event,
  input  wire logic        rx_msg_valid,
  input  wire rx_msg_t     rx_msg,
  input  wire logic [8:0]  rx_error_counter,
  input  wire logic [8:0]  tx_error_counter,
  input  wire tx_stat_t    tx_stat,
  output var  logic [2:0]  tx_empty,
  output var  logic [2:0]  abort_done,
  output var  logic        rx_full,
  output var  logic        soft_reset,
  output var  logic        wake_irq,
  output var  logic        err_irq,
  output var  logic        rx_irq,
  output var  logic        tx_irq
);

  bus_state_t      bus_ff;
  logic [7:0]      addr_ff;
  logic            soft_ff;
  logic [7:0]      rx_ien_ff;
  logic [7:0]      flags_ff;
  logic [2:0]      empty_ff;
  logic [2:0]      ack_ff;
  logic [2:0]      abt_rq_ff;
  logic [2:0]      tx_ien_ff;
  logic [1:0]      fmode_ff;
  logic [1:0]      fhit_ff;
  logic [3:0][7:0] code_ff;
  logic [3:0][7:0] mask_ff;
  logic            acc;
  logic            wr_en;
  logic [7:0]      wdat;
  logic [7:0]      rd_val;
  logic [7:0]      flag_set;
  logic [7:0]      nxt_flags;
  logic [2:0]      empty_set;
  logic [2:0]      empty_clr;
  logic [2:0]      nxt_empty;
  logic [2:0]      abort_grant;
  logic            hit_any;
  logic [1:0]      hit_idx;
  logic            accept;
  logic            exchange;

  // one byte of identifier against code, ignoring masked bits
  function automatic logic byte_match(input logic [7:0] id, input logic [7:0] code,
                                      input logic [7:0] mask);
    byte_match = &(~(id ^ code) | mask);
  endfunction

  // word-aligned slot inside a four-register bank
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    in_bank = (a[7:4] == base[7:4]) && (a[1:0] == 2'h0);
  endfunction

  assign acc   = hsel & htrans[1] & hready;
  assign wr_en = (bus_ff == BUS_WRITE);
  assign wdat  = hwdata[7:0];

  // bus slave: writes take no wait, reads one wait so that a write just
  // before is already visible; hsize is ignored, only the low data byte is used
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_ff    <= BUS_IDLE;
      addr_ff   <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (bus_ff == BUS_READ) begin
        hrdata    <= {24'h00_0000, rd_val};
        hreadyout <= 1'b1;
        bus_ff    <= BUS_IDLE;
      end else if (acc) begin
        addr_ff   <= haddr[7:0];
        bus_ff    <= hwrite ? BUS_WRITE : BUS_READ;
        hreadyout <= hwrite;
      end else begin
        bus_ff <= BUS_IDLE;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_val = 8'h00;
    if (addr_ff == `OFS_MODCTL) begin
      rd_val = {6'h00, sleep_mode, soft_ff};
    end else if (addr_ff == `OFS_RXFLG) begin
      rd_val = flags_ff;
    end else if (addr_ff == `OFS_RXIEN) begin
      rd_val = rx_ien_ff;
    end else if (addr_ff == `OFS_TXFLG) begin
      rd_val = {1'b0, ack_ff, 1'b0, empty_ff};
    end else if (addr_ff == `OFS_TXCTL) begin
      rd_val = {1'b0, abt_rq_ff, 1'b0, tx_ien_ff};
    end else if (addr_ff == `OFS_FMODE) begin
      rd_val = {2'h0, fmode_ff, 2'h0, fhit_ff};
    end else if (addr_ff == `OFS_RXERR) begin
      // counters only shown when stable: sleep or soft reset
      rd_val = (soft_ff | sleep_mode) ? rx_error_counter[7:0] : 8'h00;
    end else if (addr_ff == `OFS_TXERR) begin
      rd_val = (soft_ff | sleep_mode) ? tx_error_counter[7:0] : 8'h00;
    end else if (in_bank(addr_ff, `OFS_CODE0)) begin
      rd_val = code_ff[addr_ff[3:2]];
    end else if (in_bank(addr_ff, `OFS_MASK0)) begin
      rd_val = mask_ff[addr_ff[3:2]];
    end
  end

  // soft reset control bit, set after hard reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_ff <= `RST_SOFT;
    end else if (wr_en && addr_ff == `OFS_MODCTL) begin
      soft_ff <= wdat[0];
    end
  end
  assign soft_reset = soft_ff;

  // receive interrupt enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_ien_ff <= 8'h00;
    end else if (soft_ff) begin
      rx_ien_ff <= 8'h00;
    end else if (wr_en && addr_ff == `OFS_RXIEN) begin
      rx_ien_ff <= wdat;
    end
  end

  // acceptance filter over the incoming identifier
  always_comb begin
    hit_any = 1'b0;
    hit_idx = 2'h0;
    case (fmode_ff)
      `FM_32: begin
        // standard ids use only the first two byte pairs
        hit_any = byte_match(rx_msg.id[0], code_ff[0], mask_ff[0]) &
                  byte_match(rx_msg.id[1], code_ff[1], mask_ff[1]) &
                  (~rx_msg.ext |
                   (byte_match(rx_msg.id[2], code_ff[2], mask_ff[2]) &
                    byte_match(rx_msg.id[3], code_ff[3], mask_ff[3])));
      end
      `FM_16: begin
        for (int k = 1; k >= 0; k--) begin
          if (byte_match(rx_msg.id[0], code_ff[2*k], mask_ff[2*k]) &&
              byte_match(rx_msg.id[1], code_ff[2*k+1], mask_ff[2*k+1])) begin
            hit_any = 1'b1;
            hit_idx = 2'(k);
          end
        end
      end
      `FM_8: begin
        for (int k = 3; k >= 0; k--) begin
          if (byte_match(rx_msg.id[0], code_ff[k], mask_ff[k])) begin
            hit_any = 1'b1;
            hit_idx = 2'(k);
          end
        end
      end
      default: begin
        hit_any = 1'b0; // closed: nothing accepted
      end
    endcase
  end

  // only accepted frames are signalled; a full foreground blocks exchange
  assign accept   = rx_msg_valid & hit_any;
  assign exchange = accept & ~flags_ff[`FB_FULL];

  // flag sources; counter levels are re-asserted so a clear cannot stick
  always_comb begin
    flag_set = 8'h00;
    flag_set[`FB_WAKE] = wake_event;
    flag_set[`FB_RWRN] = (rx_error_counter > `WARN_LIM) & ~(flags_ff[`FB_RPAS] |
                         flags_ff[`FB_TPAS] | flags_ff[`FB_BOFF]);
    flag_set[`FB_TWRN] = (tx_error_counter > `WARN_LIM) & ~(flags_ff[`FB_RPAS] |
                         flags_ff[`FB_TPAS] | flags_ff[`FB_BOFF]);
    flag_set[`FB_RPAS] = (rx_error_counter > `PASS_LIM) & ~flags_ff[`FB_BOFF];
    flag_set[`FB_TPAS] = (tx_error_counter > `PASS_LIM) &
                         (tx_error_counter <= `BOFF_LIM) & ~flags_ff[`FB_BOFF];
    flag_set[`FB_BOFF] = (tx_error_counter > `BOFF_LIM);
    flag_set[`FB_OVR]  = accept & flags_ff[`FB_FULL];
    flag_set[`FB_FULL] = exchange;
  end

  // write-one-to-clear, with the set winning in the same cycle
  assign nxt_flags = (flags_ff & ~((wr_en && addr_ff == `OFS_RXFLG) ? wdat : 8'h00)) |
                     flag_set;

  // receive flags, held clear during soft reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_ff <= 8'h00;
    end else if (soft_ff) begin
      flags_ff <= 8'h00;
    end else begin
      flags_ff <= nxt_flags;
    end
  end
  assign rx_full = flags_ff[`FB_FULL];

  // hit indicator follows the foreground buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fhit_ff <= 2'h0;
    end else if (exchange) begin
      fhit_ff <= hit_idx;
    end
  end

  // filter mode, writable only while in soft reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fmode_ff <= `FM_32;
    end else if (soft_ff && wr_en && addr_ff == `OFS_FMODE) begin
      fmode_ff <= wdat[`FMODE_LSB +: 2];
    end
  end

  // code and mask banks, same soft reset lock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_ff <= '0;
      mask_ff <= '0;
    end else if (soft_ff && wr_en) begin
      if (in_bank(addr_ff, `OFS_CODE0)) begin
        code_ff[addr_ff[3:2]] <= wdat;
      end else if (in_bank(addr_ff, `OFS_MASK0)) begin
        mask_ff[addr_ff[3:2]] <= wdat;
      end
    end
  end

  // abort is granted only before start or after a failed attempt
  assign abort_grant = abt_rq_ff & ~empty_ff &
                       (~tx_stat.started | tx_stat.failed);
  assign empty_set   = tx_stat.sent | abort_grant;
  assign empty_clr   = (wr_en && addr_ff == `OFS_TXFLG) ?
                       wdat[`EMPTY_LSB +: 3] : 3'h0;
  assign nxt_empty   = (empty_ff & ~empty_clr) | empty_set;

  // transmit flags; acks follow the empty flags down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      empty_ff <= `RST_EMPTY;
      ack_ff   <= 3'h0;
    end else if (soft_ff) begin
      empty_ff <= `RST_EMPTY;
      ack_ff   <= 3'h0;
    end else begin
      empty_ff <= nxt_empty;
      ack_ff   <= (ack_ff & ~empty_clr) | abort_grant;
    end
  end
  assign tx_empty = empty_ff;

  // transmit control: requests set by cpu, dropped as buffer empties
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      abt_rq_ff <= 3'h0;
      tx_ien_ff <= 3'h0;
    end else if (soft_ff) begin
      abt_rq_ff <= 3'h0;
      tx_ien_ff <= 3'h0;
    end else begin
      if (wr_en && addr_ff == `OFS_TXCTL) begin
        tx_ien_ff <= wdat[`EMPTY_IEN_LSB +: 3];
      end
      abt_rq_ff <= (abt_rq_ff | ((wr_en && addr_ff == `OFS_TXCTL) ?
                   wdat[`ABT_RQ_LSB +: 3] : 3'h0)) & ~nxt_empty;
    end
  end

  // interrupt requests and abort pulses, registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_irq   <= 1'b0;
      err_irq    <= 1'b0;
      rx_irq     <= 1'b0;
      tx_irq     <= 1'b0;
      abort_done <= 3'h0;
    end else begin
      wake_irq   <= flags_ff[`FB_WAKE] & rx_ien_ff[`FB_WAKE];
      err_irq    <= |(flags_ff & rx_ien_ff & `ERR_BITS);
      rx_irq     <= flags_ff[`FB_FULL] & rx_ien_ff[`FB_FULL];
      tx_irq     <= |(empty_ff & tx_ien_ff);
      abort_done <= abort_grant;
    end
  end

  property p_wake_irq;
    @(posedge hclk) disable iff (!hresetn)
      (flags_ff[`FB_WAKE] & rx_ien_ff[`FB_WAKE]) |=> wake_irq;
  endproperty
  a_wake_irq: assert property (p_wake_irq)
    else $error("wake interrupt missing");

  property p_err_irq;
    @(posedge hclk) disable iff (!hresetn)
      ((flags_ff & rx_ien_ff & `ERR_BITS) == 8'h00) |=> !err_irq;
  endproperty
  a_err_irq: assert property (p_err_irq)
    else $error("error interrupt without enabled flag");

  property p_rx_irq;
    @(posedge hclk) disable iff (!hresetn)
      (flags_ff[`FB_FULL] && rx_ien_ff[`FB_FULL]) [*2] |-> rx_irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("receive interrupt missing");

  property p_soft_hold;
    @(posedge hclk) disable iff (!hresetn)
      soft_ff |=> (rx_ien_ff == 8'h00 && empty_ff == `RST_EMPTY && ack_ff == 3'h0 &&
                   abt_rq_ff == 3'h0 && tx_ien_ff == 3'h0);
  endproperty
  a_soft_hold: assert property (p_soft_hold)
    else $error("registers not held under soft reset");

  property p_ack_empty;
    @(posedge hclk) disable iff (!hresetn)
      (ack_ff & ~empty_ff) == 3'h0;
  endproperty
  a_ack_empty: assert property (p_ack_empty)
    else $error("abort ack set on a scheduled buffer");

  property p_req_drop;
    @(posedge hclk) disable iff (!hresetn)
      (abt_rq_ff & empty_ff) == 3'h0;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("abort request left on empty buffer");

  property p_grant_ok;
    @(posedge hclk) disable iff (!hresetn)
      |abort_done |-> (abort_done & ~($past(abt_rq_ff) & ~$past(empty_ff) &
                       (~$past(tx_stat.started) | $past(tx_stat.failed)))) == 3'h0;
  endproperty
  a_grant_ok: assert property (p_grant_ok)
    else $error("abort granted during transmission");

  property p_lock;
    @(posedge hclk) disable iff (!hresetn)
      !soft_ff |=> $stable(code_ff) && $stable(mask_ff) && $stable(fmode_ff);
  endproperty
  a_lock: assert property (p_lock)
    else $error("filter register changed outside soft reset");

  property p_hit_hold;
    @(posedge hclk) disable iff (!hresetn)
      !exchange |=> $stable(fhit_ff);
  endproperty
  a_hit_hold: assert property (p_hit_hold)
    else $error("hit field changed without exchange");

  property p_closed;
    @(posedge hclk) disable iff (!hresetn)
      (fmode_ff == `FM_CLOSED && !flags_ff[`FB_FULL] && !soft_ff) |=> !flags_ff[`FB_FULL];
  endproperty
  a_closed: assert property (p_closed)
    else $error("closed filter accepted a message");

  property p_tx_irq;
    @(posedge hclk) disable iff (!hresetn)
      (|(empty_ff & tx_ien_ff)) |=> tx_irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("transmit empty interrupt missing");

endmodule
`default_nettype wire

//--- verification/can_far_node_model.sv
`timescale 1ns/1ps
`default_nettype none

module can_far_node_model
  import can_flt_pkg::*;
#(
  parameter int RUN_LEN = 10
)(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [2:0] tx_empty,
  input  wire logic [2:0] stall,
  input  wire logic       fail_mode,
  input  wire logic       msg_go,
  input  wire rx_msg_t    msg_in,
  output var  tx_stat_t   tx_stat,
  output var  logic       rx_msg_valid,
  output var  rx_msg_t    rx_msg
);
  logic [2:0][4:0] cnt_ff;
  logic [2:0]      sent_ff;
  logic [2:0]      fail_ff;
  logic [2:0]      busy;
  logic            valid_ff;
  rx_msg_t         msg_ff;

  // one frame per scheduled buffer; a stalled buffer never starts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff  <= '0;
      sent_ff <= '0;
      fail_ff <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        sent_ff[i] <= 1'b0;
        fail_ff[i] <= 1'b0;
        if (tx_empty[i] || stall[i]) begin
          cnt_ff[i] <= 5'h00;
        end else if (cnt_ff[i] == 5'(RUN_LEN)) begin
          cnt_ff[i]  <= 5'h00; // a failed frame is retried, like the real bus
          sent_ff[i] <= !fail_mode;
          fail_ff[i] <= fail_mode;
        end else begin
          cnt_ff[i] <= cnt_ff[i] + 5'h01;
        end
      end
    end
  end

  // started holds through the closing pulse, so an abort cannot slip in as a frame ends
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      busy[i] = (cnt_ff[i] != 5'h00) | sent_ff[i] | fail_ff[i];
    end
  end

  assign tx_stat = {sent_ff, busy, fail_ff};

  // message lines show the inverse of the last value outside the valid cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_ff <= 1'b0;
      msg_ff   <= '0;
    end else begin
      valid_ff <= msg_go;
      msg_ff   <= msg_go ? msg_in : ~msg_ff;
    end
  end

  assign rx_msg_valid = valid_ff;
  assign rx_msg       = msg_ff;
endmodule

`default_nettype wire

//--- verification/can_irq_abort_id_filter_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "can_flt_regs.svh"

module can_irq_abort_id_filter_bench
  import can_flt_pkg::*;
;
  typedef struct packed {
    logic [1:0]  mode;
    logic        ext;
    logic [31:0] id;
    logic        ok;
    logic [1:0]  hit;
  } flt_row_t;

  logic hclk, hresetn, hsel, hwrite, hready, hresp, sleep_mode, wake_event;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, tx_empty, abort_done, stall;
  logic [8:0]  rx_error_counter, tx_error_counter;
  logic        rx_msg_valid, rx_full, soft_reset, wake_irq, err_irq, rx_irq, tx_irq;
  logic        fail_mode, msg_go;
  rx_msg_t     rx_msg, msg_in;
  tx_stat_t    tx_stat;
  int          err_total, checks, cycles;
  logic [7:0]  code [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
  logic [7:0]  mask [4] = '{8'h00, 8'h07, 8'h00, 8'h00};
  // mode, ext, id {b3,b2,b1,b0}, accepted, hit; mask1 low bits ignored
  flt_row_t    rows [8] = '{
    '{2'h0, 1'b0, 32'h9999_3512, 1'b1, 2'h0}, '{2'h0, 1'b0, 32'h0000_3413, 1'b0, 2'h0},
    '{2'h0, 1'b1, 32'h7956_3412, 1'b0, 2'h0}, '{2'h0, 1'b1, 32'h7856_3312, 1'b1, 2'h0},
    '{2'h1, 1'b0, 32'h0000_7856, 1'b1, 2'h1}, '{2'h2, 1'b0, 32'h0000_0078, 1'b1, 2'h3},
    '{2'h2, 1'b0, 32'h0000_0034, 1'b1, 2'h1}, '{2'h3, 1'b0, 32'h0000_3412, 1'b0, 2'h0}};

  logic        hreadyout_w;
  logic [2:0]  aborted = 3'h0;
  assign hready = hreadyout_w;

  can_irq_abort_id_filter u_can_irq_abort_id_filter (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout_w), .hrdata(hrdata), .hresp(hresp), .sleep_mode(sleep_mode),
    .wake_event(wake_event), .rx_msg_valid(rx_msg_valid), .rx_msg(rx_msg),
    .rx_error_counter(rx_error_counter), .tx_error_counter(tx_error_counter),
    .tx_stat(tx_stat), .tx_empty(tx_empty), .abort_done(abort_done), .rx_full(rx_full),
    .soft_reset(soft_reset), .wake_irq(wake_irq), .err_irq(err_irq), .rx_irq(rx_irq),
    .tx_irq(tx_irq));

  can_far_node_model u_can_far_node_model (
    .hclk(hclk), .hresetn(hresetn), .tx_empty(tx_empty), .stall(stall),
    .fail_mode(fail_mode), .msg_go(msg_go), .msg_in(msg_in), .tx_stat(tx_stat),
    .rx_msg_valid(rx_msg_valid), .rx_msg(rx_msg));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one single transfer; every wait ends on hready sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(what, q, {24'h000000, e});
    chk("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic send(input logic ext, input logic [31:0] id);
    msg_in <= {ext, id};
    msg_go <= 1'b1;
    @(posedge hclk);
    msg_go <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  // bounded wait for a buffer to come back empty
  task automatic wait_empty(input int b);
    int n;
    n = 0;
    while (tx_empty[b] !== 1'b1 && n < 40) begin
      @(posedge hclk);
      n++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // every abort pulse of the run, checked once near the end
  always @(posedge hclk) aborted <= aborted | abort_done;

  // cuts a hang short well above the expected run length
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = '0; sleep_mode = 1'b0; wake_event = 1'b0; rx_error_counter = 9'h050;
    tx_error_counter = 9'h000; stall = 3'h0; fail_mode = 1'b0; msg_go = 1'b0;
    msg_in = '0; err_total = 0; checks = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("soft_reset", 32'(soft_reset), 32'h1);
    rd_chk("tx_flags", `OFS_TXFLG, 8'h07);
    wr(`OFS_RXIEN, 8'hFF);
    rd_chk("rx_irq_enable", `OFS_RXIEN, 8'h00);
    wr(`OFS_TXCTL, 8'h77);
    rd_chk("tx_control", `OFS_TXCTL, 8'h00);
    rd_chk("rx_error_count", `OFS_RXERR, 8'h50);
    rd_chk("unmapped", 8'h40, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_CODE0 + 8'(4 * k), code[k]);
      wr(`OFS_MASK0 + 8'(4 * k), mask[k]);
      rd_chk("id_match_code", `OFS_CODE0 + 8'(4 * k), code[k]);
      rd_chk("id_ignore_bits", `OFS_MASK0 + 8'(4 * k), mask[k]);
    end
    // every filter mode, accepted and dropped messages
    foreach (rows[i]) begin
      wr(`OFS_MODCTL, 8'h01);
      wr(`OFS_FMODE, {2'h0, rows[i].mode, 4'h3});
      wr(`OFS_MODCTL, 8'h00);
      send(rows[i].ext, rows[i].id);
      chk("rx_full", 32'(rx_full), 32'(rows[i].ok));
      if (rows[i].ok) begin
        rd_chk("filter_hit", `OFS_FMODE, {2'h0, rows[i].mode, 2'h0, rows[i].hit});
      end
      wr(`OFS_RXFLG, 8'h01);
    end
    // running: filter registers locked, counters hidden unless asleep
    wr(`OFS_FMODE, 8'h00);
    rd_chk("filter_mode", `OFS_FMODE, 8'h31);
    wr(`OFS_CODE0, 8'hFF);
    rd_chk("id_match_code_0", `OFS_CODE0, 8'h12);
    rd_chk("rx_error_count", `OFS_RXERR, 8'h00);
    sleep_mode <= 1'b1;
    rd_chk("rx_error_count", `OFS_RXERR, 8'h50);
    rd_chk("module_control_0", `OFS_MODCTL, 8'h02);
    sleep_mode <= 1'b0;
    wr(`OFS_MODCTL, 8'h01);
    wr(`OFS_FMODE, 8'h00);
    wr(`OFS_MODCTL, 8'h00);
    // receive interrupt, then overrun while full
    wr(`OFS_RXIEN, 8'h01);
    send(1'b0, 32'h0000_3412);
    chk("rx_irq", 32'(rx_irq), 32'h1);
    send(1'b0, 32'h0000_3412);
    rd_chk("rx_flags", `OFS_RXFLG, 8'h03);
    chk("err_irq", 32'(err_irq), 32'h0);
    wr(`OFS_RXIEN, 8'h03);
    repeat (2) @(posedge hclk);
    chk("err_irq", 32'(err_irq), 32'h1);
    wr(`OFS_RXFLG, 8'h03);
    repeat (2) @(posedge hclk);
    chk("rx_irq", 32'(rx_irq | err_irq), 32'h0);
    // warning threshold is strictly above 96
    wr(`OFS_RXIEN, 8'h40);
    rx_error_counter <= 9'h060;
    repeat (3) @(posedge hclk);
    chk("err_irq", 32'(err_irq), 32'h0);
    rx_error_counter <= 9'h061;
    repeat (3) @(posedge hclk);
    chk("err_irq", 32'(err_irq), 32'h1);
    rd_chk("rx_flags", `OFS_RXFLG, 8'h40);
    rx_error_counter <= 9'h050;
    wr(`OFS_RXIEN, 8'h04);
    tx_error_counter <= 9'h100;
    repeat (3) @(posedge hclk);
    chk("err_irq", 32'(err_irq), 32'h1);
    tx_error_counter <= 9'h000;
    wr(`OFS_RXFLG, 8'h7C);
    repeat (3) @(posedge hclk);
    chk("err_irq", 32'(err_irq), 32'h0);
    // wake interrupt follows its enable, flag stays
    wr(`OFS_RXIEN, 8'h80);
    wake_event <= 1'b1;
    @(posedge hclk);
    wake_event <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("wake_irq", 32'(wake_irq), 32'h1);
    wr(`OFS_RXIEN, 8'h00);
    repeat (2) @(posedge hclk);
    chk("wake_irq", 32'(wake_irq), 32'h0);
    rd_chk("rx_flags", `OFS_RXFLG, 8'h80);
    // abort before start; abort asked in its own write, never with a clear
    stall <= 3'h1; // no buffer contents are touched while scheduled
    wr(`OFS_TXCTL, 8'h01);
    repeat (2) @(posedge hclk);
    chk("tx_irq", 32'(tx_irq), 32'h1);
    wr(`OFS_TXFLG, 8'h01);
    rd_chk("tx_flags", `OFS_TXFLG, 8'h06);
    chk("tx_irq", 32'(tx_irq), 32'h0);
    wr(`OFS_TXFLG, 8'h00);
    rd_chk("tx_flags", `OFS_TXFLG, 8'h06);
    wr(`OFS_TXCTL, 8'h11);
    rd_chk("tx_flags", `OFS_TXFLG, 8'h17);
    chk("tx_irq", 32'(tx_irq), 32'h1);
    rd_chk("tx_control", `OFS_TXCTL, 8'h01);
    wr(`OFS_TXFLG, 8'h11);
    rd_chk("tx_flags", `OFS_TXFLG, 8'h06);
    stall <= 3'h0;
    wait_empty(0);
    rd_chk("tx_flags", `OFS_TXFLG, 8'h07);
    // abort during a running frame is not granted
    wr(`OFS_TXFLG, 8'h02);
    repeat (3) @(posedge hclk);
    wr(`OFS_TXCTL, 8'h21);
    wait_empty(1);
    rd_chk("tx_flags", `OFS_TXFLG, 8'h07);
    // a failed frame lets the abort through
    fail_mode <= 1'b1;
    wr(`OFS_TXFLG, 8'h04);
    repeat (3) @(posedge hclk);
    wr(`OFS_TXCTL, 8'h41);
    wait_empty(2);
    rd_chk("tx_flags", `OFS_TXFLG, 8'h47);
    chk("abort_done", 32'(aborted), 32'h5);
    fail_mode <= 1'b0;
    wr(`OFS_MODCTL, 8'h01);
    rd_chk("tx_flags", `OFS_TXFLG, 8'h07);
    rd_chk("tx_control", `OFS_TXCTL, 8'h00);
    end_of_test();
  end
endmodule

`default_nettype wire
